// file: power_status_wake_timer.sv
// Power source status encoder, flash/PLL guard, reference gate and wake timer
// Functional notes
// - Both analog-good and main-good high report code 000.
// - Analog-good low with main-good high reports code 001.
// - Main indicators low, both core indicators high report code 010.
// - Battery, core-good low, above-two-volts high: code 011 and flash writes blocked.
// - In code 011 with trim fuse bit 5 blown, clear fast-PLL select bit.
// - Battery with core below two volts reports code 101.
// - Power code is read-only, special-function register F9 bits 2:0.
// - Writing the arm bit arms the timer and loads the reload byte.
// - Armed timer starts only on sleep or display-only request.
// - Reference disable bit suppresses routing the reference to its pin.
`timescale 1ns/1ps
module power_status_wake_timer #(
   parameter int RELOAD_WIDTH = 8
) (
   // Clock and reset
   input  wire logic                                clk,
   input  wire logic                                resetn,
   // Register access port
   input  wire power_status_pkg::reg_req_t          reg_req,
   output logic [7:0]                               reg_rdata,
   // Supply indicators from analog comparators
   input  wire power_status_pkg::supply_status_t    supply_in,
   input  wire logic [power_status_pkg::FUSE_WIDTH-1:0] supply_trim_fuse,
   // Processor mode requests and timebase
   input  wire logic                                sleep_request,
   input  wire logic                                display_only_request,
   input  wire logic                                sec_tick,
   // Controls out
   output logic                                     flash_write_inhibit,
   output logic                                     pll_fast_select,
   output logic                                     adc_ref_to_pin,
   output logic                                     wake_event,
   output logic                                     wake_timer_running
);

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   // Power code from supply indicators
   function automatic logic [2:0] power_code(input power_status_pkg::supply_status_t s);
      logic [2:0] c;
      c = power_status_pkg::CODE_BAT_BROWN;
      if (s.main_supply_good) begin
         if (s.analog_supply_good) begin
            c = power_status_pkg::CODE_MAIN_OK;
         end else begin
            c = power_status_pkg::CODE_MAIN_LOW;
         end
      end else if (s.core_supply_good && s.core_above_two_volts) begin
         c = power_status_pkg::CODE_BAT_OK;
      end else if (s.core_above_two_volts) begin
         c = power_status_pkg::CODE_BAT_WEAK;
      end
      return c;
   endfunction

   // Address match in the selected space
   function automatic logic hit(input power_status_pkg::reg_req_t r, input logic sfr, input logic [15:0] a);
      return (r.sfr == sfr) && (r.addr == a);
   endfunction

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   power_status_pkg::supply_status_t supply_s1_r, supply_s2_r;
   logic [power_status_pkg::FUSE_WIDTH-1:0] fuse_s1_r, fuse_s2_r;

   // Two flops on every asynchronous level
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         supply_s1_r <= power_status_pkg::SUPPLY_RESET;
         supply_s2_r <= power_status_pkg::SUPPLY_RESET;
         fuse_s1_r   <= '0;
         fuse_s2_r   <= '0;
      end else begin
         supply_s1_r <= supply_in;
         supply_s2_r <= supply_s1_r;
         fuse_s1_r   <= supply_trim_fuse;
         fuse_s2_r   <= fuse_s1_r;
      end
   end

   // ---------------------------------------------------------------
   // Power code and registers
   // ---------------------------------------------------------------
   logic [2:0]              code_r, code_nxt;
   logic                    pll_fast_r, pll_fast_nxt;
   logic                    ref_cal_r, ref_cal_nxt;
   logic                    ref_dis_r, ref_dis_nxt;
   logic [RELOAD_WIDTH-1:0] reload_r, reload_nxt;
   logic                    arm_r, arm_nxt;
   logic [7:0]              rdata_r, rdata_nxt;
   logic                    arm_load;
   logic                    timer_armed;
   logic                    timer_expire;
   logic                    wr_pll, wr_ref, wr_reload, wr_arm;

   assign wr_pll    = reg_req.wr && hit(reg_req, 1'b0, power_status_pkg::ADDR_PLL_CTRL);
   assign wr_ref    = reg_req.wr && hit(reg_req, 1'b0, power_status_pkg::ADDR_ADC_REF);
   assign wr_reload = reg_req.wr && hit(reg_req, 1'b0, power_status_pkg::ADDR_WAKE_RELOAD);
   assign wr_arm    = reg_req.wr && hit(reg_req, 1'b0, power_status_pkg::ADDR_WAKE_ARM);

   // A written one on the arm bit loads the timer
   assign arm_load = wr_arm && reg_req.wdata[power_status_pkg::BIT_WAKE_ARM];

   // Next values of code, control bits and read data
   always_comb begin
      code_nxt     = power_code(supply_s2_r);
      pll_fast_nxt = pll_fast_r;
      ref_cal_nxt  = ref_cal_r;
      ref_dis_nxt  = ref_dis_r;
      reload_nxt   = reload_r;
      arm_nxt      = arm_r;
      rdata_nxt    = rdata_r;
      if (wr_pll) begin
         pll_fast_nxt = reg_req.wdata[power_status_pkg::BIT_PLL_FAST];
      end
      // Weak battery with trim fuse blown forces the fast PLL off
      if ((code_r == power_status_pkg::CODE_BAT_WEAK) && fuse_s2_r[power_status_pkg::FUSE_PLL_BIT]) begin
         pll_fast_nxt = 1'b0;
      end
      if (wr_ref) begin
         ref_cal_nxt = reg_req.wdata[power_status_pkg::BIT_REF_CAL];
         ref_dis_nxt = reg_req.wdata[power_status_pkg::BIT_REF_DIS];
      end
      if (wr_reload) begin
         reload_nxt = reg_req.wdata[RELOAD_WIDTH-1:0];
      end
      // Expiry clears the arm bit; a write in the same cycle wins
      if (timer_expire) begin
         arm_nxt = 1'b0;
      end
      if (wr_arm) begin
         arm_nxt = reg_req.wdata[power_status_pkg::BIT_WAKE_ARM];
      end
      if (reg_req.rd) begin
         rdata_nxt = power_status_pkg::RDATA_NONE;
         if (hit(reg_req, 1'b1, power_status_pkg::SFR_POWER_STATE)) begin
            rdata_nxt[2:0] = code_r;
         end else if (hit(reg_req, 1'b0, power_status_pkg::ADDR_PLL_CTRL)) begin
            rdata_nxt[power_status_pkg::BIT_PLL_FAST] = pll_fast_r;
         end else if (hit(reg_req, 1'b0, power_status_pkg::ADDR_ADC_REF)) begin
            rdata_nxt[power_status_pkg::BIT_REF_CAL] = ref_cal_r;
            rdata_nxt[power_status_pkg::BIT_REF_DIS] = ref_dis_r;
         end else if (hit(reg_req, 1'b0, power_status_pkg::ADDR_WAKE_RELOAD)) begin
            rdata_nxt[RELOAD_WIDTH-1:0] = reload_r;
         end else if (hit(reg_req, 1'b0, power_status_pkg::ADDR_WAKE_ARM)) begin
            rdata_nxt[power_status_pkg::BIT_WAKE_ARM] = arm_r;
         end
      end
   end

   // Register stage
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         code_r     <= power_status_pkg::CODE_RESET;
         pll_fast_r <= power_status_pkg::PLL_FAST_RESET;
         ref_cal_r  <= power_status_pkg::REF_CAL_RESET;
         ref_dis_r  <= power_status_pkg::REF_DIS_RESET;
         reload_r   <= power_status_pkg::WAKE_RELOAD_RESET[RELOAD_WIDTH-1:0];
         arm_r      <= power_status_pkg::WAKE_ARM_RESET;
         rdata_r    <= power_status_pkg::RDATA_NONE;
      end else begin
         code_r     <= code_nxt;
         pll_fast_r <= pll_fast_nxt;
         ref_cal_r  <= ref_cal_nxt;
         ref_dis_r  <= ref_dis_nxt;
         reload_r   <= reload_nxt;
         arm_r      <= arm_nxt;
         rdata_r    <= rdata_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Wake timer
   // ---------------------------------------------------------------
   wake_timer #(
      .WIDTH        (RELOAD_WIDTH)
   ) u_wake_timer (
      .clk          (clk),
      .resetn       (resetn),
      .arm_load     (arm_load),
      .reload       (reload_r),
      .mode_request (sleep_request || display_only_request),
      .sec_tick     (sec_tick),
      .armed        (timer_armed),
      .running      (wake_timer_running),
      .expire       (timer_expire)
   );

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign reg_rdata           = rdata_r;
   assign flash_write_inhibit = (code_r == power_status_pkg::CODE_BAT_WEAK);
   assign pll_fast_select     = pll_fast_r;
   assign adc_ref_to_pin      = ref_cal_r && !ref_dis_r;
   assign wake_event          = timer_expire;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_main_ok;
      supply_s2_r.main_supply_good && supply_s2_r.analog_supply_good |=> code_r == 3'h0;
   endproperty
   a_main_ok: assert property (p_main_ok) else $error("code not 000 on good main");

   property p_main_low;
      supply_s2_r.main_supply_good && !supply_s2_r.analog_supply_good |=> code_r == 3'h1;
   endproperty
   a_main_low: assert property (p_main_low) else $error("code not 001 on weak analog");

   property p_bat_ok;
      !supply_s2_r.main_supply_good && !supply_s2_r.analog_supply_good
         && supply_s2_r.core_supply_good && supply_s2_r.core_above_two_volts |=> code_r == 3'h2;
   endproperty
   a_bat_ok: assert property (p_bat_ok) else $error("code not 010 on healthy battery");

   property p_bat_weak;
      !supply_s2_r.main_supply_good && !supply_s2_r.core_supply_good && supply_s2_r.core_above_two_volts
         |=> code_r == 3'h3 && flash_write_inhibit;
   endproperty
   a_bat_weak: assert property (p_bat_weak) else $error("weak battery not coded or flash open");

   property p_pll_off;
      code_r == 3'h3 && fuse_s2_r[power_status_pkg::FUSE_PLL_BIT] |=> !pll_fast_select;
   endproperty
   a_pll_off: assert property (p_pll_off) else $error("fast PLL not cleared");

   property p_brown;
      !supply_s2_r.main_supply_good && !supply_s2_r.core_above_two_volts |=> code_r == 3'h5;
   endproperty
   a_brown: assert property (p_brown) else $error("code not 101 below two volts");

   property p_code_read;
      reg_req.rd && reg_req.sfr && reg_req.addr == 16'h00f9 |=> reg_rdata == {5'h00, $past(code_r)};
   endproperty
   a_code_read: assert property (p_code_read) else $error("status read mismatch");

   property p_ref_gate;
      wr_ref && reg_req.wdata[power_status_pkg::BIT_REF_DIS] |=> ref_dis_r && !adc_ref_to_pin;
   endproperty
   a_ref_gate: assert property (p_ref_gate) else $error("reference routed while disabled");

   property p_arm_sets;
      arm_load |=> arm_r && timer_armed;
   endproperty
   a_arm_sets: assert property (p_arm_sets) else $error("arm bit not set by write");

   c_weak:    cover property (code_r == 3'h3);
   c_brown:   cover property (code_r == 3'h5);
   c_wake:    cover property (timer_armed ##1 wake_timer_running);
   c_expired: cover property (wake_event);

endmodule // power_status_wake_timer

// file: power_status_pkg.sv
// Shared constants and types for the power status and wake timer block
package power_status_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [15:0] SFR_POWER_STATE  = 16'h00f9;
   localparam logic [15:0] ADDR_PLL_CTRL    = 16'h2200;
   localparam logic [15:0] ADDR_ADC_REF     = 16'h2704;
   localparam logic [15:0] ADDR_WAKE_RELOAD = 16'h2880;
   localparam logic [15:0] ADDR_WAKE_ARM    = 16'h28b2;

   // Field positions
   localparam int BIT_PLL_FAST  = 4;
   localparam int BIT_REF_CAL   = 7;
   localparam int BIT_REF_DIS   = 6;
   localparam int BIT_WAKE_ARM  = 5;
   localparam int FUSE_PLL_BIT  = 5;
   localparam int FUSE_WIDTH    = 8;

   // Reset values
   localparam logic       PLL_FAST_RESET    = 1'h0;
   localparam logic       REF_CAL_RESET     = 1'h0;
   localparam logic       REF_DIS_RESET     = 1'h0;
   localparam logic       WAKE_ARM_RESET    = 1'h0;
   localparam logic [7:0] WAKE_RELOAD_RESET = 8'h00;
   localparam logic [7:0] RDATA_NONE        = 8'h00;

   // ---------------------------------------------------------------
   // Power state codes
   // ---------------------------------------------------------------
   localparam logic [2:0] CODE_MAIN_OK    = 3'h0;
   localparam logic [2:0] CODE_MAIN_LOW   = 3'h1;
   localparam logic [2:0] CODE_BAT_OK     = 3'h2;
   localparam logic [2:0] CODE_BAT_WEAK   = 3'h3;
   localparam logic [2:0] CODE_BAT_BROWN  = 3'h5;
   localparam logic [2:0] CODE_RESET      = 3'h0;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic analog_supply_good;
      logic main_supply_good;
      logic core_supply_good;
      logic core_above_two_volts;
   } supply_status_t;

   localparam supply_status_t SUPPLY_RESET = '0;

   typedef struct packed {
      logic        sfr;     // 1: special-function space, 0: I/O RAM
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [7:0]  wdata;
   } reg_req_t;

   typedef enum logic [2:0] {
      W_IDLE  = 3'b001,
      W_ARMED = 3'b010,
      W_RUN   = 3'b100
   } wake_state_t;

endpackage

// file: wake_timer.sv
// One-byte wake-up timer counting whole seconds
`timescale 1ns/1ps
module wake_timer #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // Control
   input  wire logic             arm_load,
   input  wire logic [WIDTH-1:0] reload,
   input  wire logic             mode_request,
   input  wire logic             sec_tick,
   // Status
   output logic                  armed,
   output logic                  running,
   output logic                  expire
);

   // ---------------------------------------------------------------
   // Timer state
   // ---------------------------------------------------------------
   power_status_pkg::wake_state_t state_r, state_nxt;
   logic [WIDTH-1:0]              count_r, count_nxt;
   logic                          expire_r, expire_nxt;

   // Next state of the timer
   always_comb begin
      state_nxt  = state_r;
      count_nxt  = count_r;
      expire_nxt = 1'b0;
      case (state_r)
         power_status_pkg::W_IDLE: begin
         end
         power_status_pkg::W_ARMED: begin
            if (mode_request) begin
               state_nxt = power_status_pkg::W_RUN;
            end
         end
         power_status_pkg::W_RUN: begin
            if (sec_tick) begin
               if (count_r == '0) begin
                  state_nxt  = power_status_pkg::W_IDLE;
                  expire_nxt = 1'b1;
               end else begin
                  count_nxt = count_r - 1'b1;
               end
            end
         end
         default: begin
            state_nxt = power_status_pkg::W_IDLE;
         end
      endcase
      // Arming reloads from any state
      if (arm_load) begin
         state_nxt = power_status_pkg::W_ARMED;
         count_nxt = reload;
      end
   end

   // Timer registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r  <= power_status_pkg::W_IDLE;
         count_r  <= '0;
         expire_r <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         count_r  <= count_nxt;
         expire_r <= expire_nxt;
      end
   end

   assign armed   = (state_r == power_status_pkg::W_ARMED);
   assign running = (state_r == power_status_pkg::W_RUN);
   assign expire  = expire_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_arm_loads;
      arm_load |=> armed && (count_r == $past(reload));
   endproperty
   a_arm_loads: assert property (p_arm_loads) else $error("arm did not load timer");

   property p_wait_mode;
      armed && !mode_request && !arm_load |=> armed && !running;
   endproperty
   a_wait_mode: assert property (p_wait_mode) else $error("timer ran without mode request");

   property p_last_second;
      running && sec_tick && (count_r == '0) && !arm_load |=> expire && !running;
   endproperty
   a_last_second: assert property (p_last_second) else $error("expiry missed at zero");

   property p_count_down;
      running && sec_tick && (count_r != '0) && !arm_load |=> running && (count_r == $past(count_r) - 1'b1);
   endproperty
   a_count_down: assert property (p_count_down) else $error("count did not step per second");

   c_expire: cover property (expire);

endmodule // wake_timer

// file: power_status_wake_timer_test.sv
// Self-checking bench for the power status and wake timer block
`timescale 1ns/1ps
module power_status_wake_timer_test;

   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic                                    clk;
   logic                                    resetn;
   power_status_pkg::reg_req_t              reg_req;
   logic [7:0]                              reg_rdata;
   power_status_pkg::supply_status_t        supply_in;
   logic [power_status_pkg::FUSE_WIDTH-1:0] supply_trim_fuse;
   logic                                    sleep_request;
   logic                                    display_only_request;
   logic                                    sec_tick;
   logic                                    flash_write_inhibit;
   logic                                    pll_fast_select;
   logic                                    adc_ref_to_pin;
   logic                                    wake_event;
   logic                                    wake_timer_running;
   int                                      fails;
   int                                      n_checks;
   logic [31:0]                             seed;
   logic [7:0]                              rd_val;

   power_status_wake_timer #(.RELOAD_WIDTH(8)) u_power_status_wake_timer (
      .clk                  (clk),
      .resetn               (resetn),
      .reg_req              (reg_req),
      .reg_rdata            (reg_rdata),
      .supply_in            (supply_in),
      .supply_trim_fuse     (supply_trim_fuse),
      .sleep_request        (sleep_request),
      .display_only_request (display_only_request),
      .sec_tick             (sec_tick),
      .flash_write_inhibit  (flash_write_inhibit),
      .pll_fast_select      (pll_fast_select),
      .adc_ref_to_pin       (adc_ref_to_pin),
      .wake_event           (wake_event),
      .wake_timer_running   (wake_timer_running)
   );

   // Free-running 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // Model and helpers
   // ---------------------------------------------------------------
   // Xorshift source for fuse noise and reload values
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Expected power code from analog, main, core, above-two-volts
   function automatic int model_code(input int s);
      if (s[2] && s[3]) return 0;
      if (s[2]) return 1;
      if (s[1] && s[0]) return 2;
      if (s[0]) return 3;
      return 5;
   endfunction

   task automatic step();
      @(posedge clk);
      #1;
   endtask

   // One bus cycle, then an idle cycle so strobes never re-fire
   task automatic reg_access(input logic sfr, input logic [15:0] addr, input logic wr, input logic [7:0] data);
      reg_req = '{sfr: sfr, addr: addr, wr: wr, rd: !wr, wdata: data};
      step();
      rd_val = reg_rdata;
      reg_req = '{sfr: 1'b0, addr: 16'h0000, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
      step();
   endtask

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic complete_run();
      if (fails == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      #2000000;
      fails++;
      $display("CHECK FAILED %0t run limit reached", $time);
      complete_run();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      int         exp_code;
      int         n;
      logic       exp_pll;
      logic [7:0] fz;
      logic [7:0] rl;
      seed = 32'h8821;
      fails = 0;
      n_checks = 0;
      resetn = 1'b0;
      reg_req = '{sfr: 1'b0, addr: 16'h0000, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
      supply_in = power_status_pkg::supply_status_t'(4'hf);
      supply_trim_fuse = 8'h00;
      sleep_request = 1'b0;
      display_only_request = 1'b0;
      sec_tick = 1'b0;
      repeat (12) @(posedge clk);
      #1;
      chk_reg(reg_rdata, 8'h00, "rdata in reset");
      chk_bit(wake_event, 1'b0, "wake in reset");
      chk_bit(pll_fast_select, 1'b0, "pll in reset");
      resetn = 1'b1;
      repeat (4) step();
      // Reset values and an unmapped place
      reg_access(1'b1, power_status_pkg::SFR_POWER_STATE, 1'b0, 8'h00);
      chk_reg(rd_val, 8'h00, "code after reset");
      reg_access(1'b0, power_status_pkg::ADDR_ADC_REF, 1'b0, 8'h00);
      chk_reg(rd_val & 8'hc0, 8'h00, "ref reset");
      reg_access(1'b0, power_status_pkg::ADDR_WAKE_RELOAD, 1'b0, 8'h00);
      chk_reg(rd_val, 8'h00, "reload reset");
      reg_access(1'b0, power_status_pkg::ADDR_WAKE_ARM, 1'b0, 8'h00);
      chk_reg(rd_val & 8'h20, 8'h00, "arm reset");
      reg_access(1'b0, 16'h1234, 1'b0, 8'h00);
      chk_reg(rd_val, 8'h00, "unmapped read");
      // Every supply combination, trim fuse bit 5 clear then blown
      for (int s = 0; s < 32; s++) begin
         fz = 8'(rnd() >> 8);
         fz[5] = s[4];
         supply_trim_fuse = fz;
         supply_in = power_status_pkg::supply_status_t'(s[3:0]);
         exp_code = model_code(s % 16);
         exp_pll = !(exp_code == 3 && s >= 16);
         repeat (4) step();
         reg_access(1'b0, power_status_pkg::ADDR_PLL_CTRL, 1'b1, 8'h10);
         reg_access(1'b1, power_status_pkg::SFR_POWER_STATE, 1'b0, 8'h00);
         chk_reg(rd_val, 8'(exp_code), "power code");
         chk_bit(flash_write_inhibit, exp_code == 3, "flash inhibit");
         chk_bit(pll_fast_select, exp_pll, "pll fast");
         reg_access(1'b0, power_status_pkg::ADDR_PLL_CTRL, 1'b0, 8'h00);
         chk_reg(rd_val & 8'h10, exp_pll ? 8'h10 : 8'h00, "pll reg");
         reg_access(1'b1, power_status_pkg::SFR_POWER_STATE, 1'b1, 8'hff);
         reg_access(1'b1, power_status_pkg::SFR_POWER_STATE, 1'b0, 8'h00);
         chk_reg(rd_val, 8'(exp_code), "code write ignored");
      end
      // Reference request against disable
      for (int v = 0; v < 4; v++) begin
         reg_access(1'b0, power_status_pkg::ADDR_ADC_REF, 1'b1, {v[1:0], 6'h00});
         chk_bit(adc_ref_to_pin, v[1] && !v[0], "ref to pin");
         reg_access(1'b0, power_status_pkg::ADDR_ADC_REF, 1'b0, 8'h00);
         chk_reg(rd_val & 8'hc0, {v[1:0], 6'h00}, "ref reg");
      end
      // Wake timer runs, both mode requests, reload 0, 1, random, 255
      for (int k = 0; k < 6; k++) begin
         rl = (k < 2) ? 8'(k) : (k == 5) ? 8'hff : 8'(rnd() % 6);
         reg_access(1'b0, power_status_pkg::ADDR_WAKE_RELOAD, 1'b1, rl);
         reg_access(1'b0, power_status_pkg::ADDR_WAKE_ARM, 1'b1, 8'h20);
         reg_access(1'b0, power_status_pkg::ADDR_WAKE_RELOAD, 1'b0, 8'h00);
         chk_reg(rd_val, rl, "reload reg");
         reg_access(1'b0, power_status_pkg::ADDR_WAKE_ARM, 1'b0, 8'h00);
         chk_reg(rd_val & 8'h20, 8'h20, "arm set");
         // A tick while only armed changes nothing
         sec_tick = 1'b1;
         step();
         sec_tick = 1'b0;
         chk_bit(wake_event, 1'b0, "tick while armed");
         chk_bit(wake_timer_running, 1'b0, "idle until mode");
         if (k[0]) begin
            sleep_request = 1'b1;
         end else begin
            display_only_request = 1'b1;
         end
         n = 0;
         while (wake_timer_running !== 1'b1 && n < 4) begin
            step();
            n++;
         end
         chk_bit(wake_timer_running, 1'b1, "timer running");
         for (int i = 0; i <= int'(rl); i++) begin
            sec_tick = 1'b1;
            step();
            sec_tick = 1'b0;
            chk_bit(wake_event, i == int'(rl), "wake pulse");
            chk_bit(wake_timer_running, i != int'(rl), "running level");
            step();
            chk_bit(wake_event, 1'b0, "wake one cycle");
         end
         step();
         chk_bit(wake_timer_running, 1'b0, "no restart unarmed");
         sleep_request = 1'b0;
         display_only_request = 1'b0;
         reg_access(1'b0, power_status_pkg::ADDR_WAKE_ARM, 1'b0, 8'h00);
         chk_reg(rd_val & 8'h20, 8'h00, "arm cleared");
      end
      // Reset in mid-count drops the timer and the registers
      reg_access(1'b0, power_status_pkg::ADDR_WAKE_ARM, 1'b1, 8'h20);
      sleep_request = 1'b1;
      repeat (3) step();
      chk_bit(wake_timer_running, 1'b1, "running before reset");
      resetn = 1'b0;
      step();
      chk_bit(wake_timer_running, 1'b0, "running in reset");
      chk_bit(wake_event, 1'b0, "wake in mid reset");
      resetn = 1'b1;
      sleep_request = 1'b0;
      repeat (4) step();
      chk_bit(wake_timer_running, 1'b0, "idle after reset");
      reg_access(1'b0, power_status_pkg::ADDR_WAKE_ARM, 1'b0, 8'h00);
      chk_reg(rd_val & 8'h20, 8'h00, "arm after reset");
      reg_access(1'b0, power_status_pkg::ADDR_WAKE_RELOAD, 1'b0, 8'h00);
      chk_reg(rd_val, 8'h00, "reload after reset");
      complete_run();
   end

endmodule // power_status_wake_timer_test
